// ---- rtl/rpu_map.svh ----
// Register offsets, field positions and reset values of the ROM patch unit
//
// Operation
// [R01] Enable bits 0..5 arm slots one to six
// [R02] Enabled slot hit substitutes its replacement byte
// [R03] Disabled slot never substitutes, ROM passes through
// [R04] Enable bits 7 and 6 unimplemented, ignored
// [R05] Replacement data registers normally write-only
// [R06] Read-open bit makes replacement data readable
// [R07] Address, enable, read-open registers plain read/write
// [R08] Data writes always ordinary; reads gated
// [R09] Controller writes high, low, then data
// [R10] Controller enables slots after programming them
// [R11] Controller clears enable before changing slots
// [R12] Low address register compared with low byte; the comparator matches it against address bits 7..0
// [R13] Loader programs slots before user code
// [R14] External patch memory uses SPI-compatible protocol; the unit has no external memory, replacement bytes sit in slot registers
// [R15] High address register holds address bits 15..8
// [R16] Read-open register bits 5..0, upper unused
// [R17] Reset clears enable and read-open registers
`ifndef RPU_MAP_SVH
`define RPU_MAP_SVH

// Device registers on the internal bus
`define RPU_SLOT_BASE      16'h0C80
`define RPU_SLOT_STRIDE    16'h0003
`define RPU_OFS_ADDR_HIGH  16'h0000
`define RPU_OFS_ADDR_LOW   16'h0001
`define RPU_OFS_DATA       16'h0002
`define RPU_ENABLE_ADDR    16'h0077
`define RPU_READ_OPEN_ADDR 16'h0078
`define RPU_ENABLE_RST     8'h00
`define RPU_READ_OPEN_RST  8'h00
`define RPU_SLOT_MAX       6

// Controller registers on APB
`define RPU_APB_CMD_ADDR   12'h000
`define RPU_APB_CMD_WDATA  12'h004
`define RPU_APB_CMD_CTRL   12'h008
`define RPU_APB_STATUS     12'h00C
`define RPU_CTRL_WRITE_BIT 0
`define RPU_CTRL_READ_BIT  1
`define RPU_STAT_BUSY_BIT  0
`define RPU_STAT_RDATA_LSB 8

`endif

// ---- rtl/rpu_pkg.sv ----
// Types shared by the ROM patch unit and its controller
package rpu_pkg;
  typedef logic [15:0] rpu_addr_t;
  typedef logic [7:0]  rpu_byte_t;
  typedef enum logic [1:0] {
    RPU_IDLE  = 2'b00,
    RPU_ISSUE = 2'b01,
    RPU_WAIT  = 2'b10
  } rpu_state_e;
endpackage

// ---- rtl/rpu_if.sv ----
// Internal bus between the controlling CPU side and the ROM patch unit
`timescale 1ns/100ps
interface rpu_if;
  logic        req;
  logic        we;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        ack;
  logic [7:0]  rdata;
  modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
  modport ctl (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// ---- rtl/rpu_slot.sv ----
// One patch slot: high and low match address, replacement byte, comparator
`timescale 1ns/100ps
`include "rpu_map.svh"
module rpu_slot
  import rpu_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      srst,
  input  wire logic      wr_high,
  input  wire logic      wr_low,
  input  wire logic      wr_data,
  input  wire rpu_byte_t wdata,
  input  wire logic      slot_enable,
  input  wire rpu_addr_t rom_addr,
  output rpu_byte_t      addr_high,
  output rpu_byte_t      addr_low,
  output rpu_byte_t      data,
  output logic           hit
);
  rpu_byte_t high_ff;
  rpu_byte_t low_ff;
  rpu_byte_t data_ff;

  // Data writes are accepted regardless of read-open state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      high_ff <= 8'h00;
      low_ff  <= 8'h00;
      data_ff <= 8'h00;
    end else begin
      if (wr_high) high_ff <= wdata; // [R15]
      if (wr_low) low_ff <= wdata;   // [R12]
      if (wr_data) data_ff <= wdata; // [R08]
    end
  end

  assign addr_high = high_ff;
  assign addr_low  = low_ff;
  assign data      = data_ff;
  assign hit       = slot_enable && ({high_ff, low_ff} == rom_addr); // [R03] [R12] [R15]
endmodule // rpu_slot

// ---- rtl/rpu_device.sv ----
// ROM patch unit: slot registers on the internal bus and fetch substitution
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "rpu_map.svh"
module rpu_device
  import rpu_pkg::*;
#(
  parameter int SLOTS = `RPU_SLOT_MAX
)(
  input  wire logic      core_clk,
  input  wire logic      srst,
  rpu_if.dev             bus,
  input  wire logic      rom_rd,
  input  wire rpu_addr_t rom_addr,
  input  wire rpu_byte_t rom_rdata,
  output rpu_byte_t      fetch_data,
  output logic           fetch_valid,
  output logic           fetch_patched
);
  if (SLOTS < 1 || SLOTS > `RPU_SLOT_MAX) begin : g_bad_slots
    $error("rpu_device: SLOTS must be 1..6");
  end

  logic [7:0]      patch_slot_enable_ff;
  logic [7:0]      patch_data_read_open_ff;
  logic            ack_ff;
  rpu_byte_t       rdata_ff;
  rpu_byte_t       fetch_data_ff;
  logic            fetch_valid_ff;
  logic            fetch_patched_ff;

  logic [SLOTS-1:0] hit;
  logic [SLOTS-1:0] rd_sel;
  rpu_byte_t        rd_val [SLOTS];
  rpu_byte_t        slot_dat [SLOTS];

  wire bus_wr    = bus.req && bus.we;
  wire sel_en    = bus.addr == `RPU_ENABLE_ADDR;
  wire sel_open  = bus.addr == `RPU_READ_OPEN_ADDR;

  for (genvar i = 0; i < SLOTS; i++) begin : g_slot
    localparam rpu_addr_t BASE = 16'(`RPU_SLOT_BASE + `RPU_SLOT_STRIDE * i);
    wire sel_hi  = bus.addr == 16'(BASE + `RPU_OFS_ADDR_HIGH);
    wire sel_lo  = bus.addr == 16'(BASE + `RPU_OFS_ADDR_LOW);
    wire sel_dat = bus.addr == 16'(BASE + `RPU_OFS_DATA);
    rpu_byte_t hi_q;
    rpu_byte_t lo_q;

    rpu_slot u_slot (
      .core_clk    (core_clk),
      .srst        (srst),
      .wr_high     (bus_wr && sel_hi),
      .wr_low      (bus_wr && sel_lo),
      .wr_data     (bus_wr && sel_dat),  // [R05] [R08]
      .wdata       (bus.wdata),
      .slot_enable (patch_slot_enable_ff[i]), // [R01]
      .rom_addr    (rom_addr),
      .addr_high   (hi_q),
      .addr_low    (lo_q),
      .data        (slot_dat[i]),
      .hit         (hit[i])
    );

    // Replacement byte is readable only while its read-open bit is set
    wire dat_open = sel_dat && patch_data_read_open_ff[i]; // [R06] [R16]
    assign rd_sel[i] = sel_hi || sel_lo || dat_open;      // [R07]
    assign rd_val[i] = sel_hi ? hi_q : (sel_lo ? lo_q : slot_dat[i]);
  end

  // Unused enable and read-open bits, unopened data and unmapped addresses read 0
  rpu_byte_t rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (sel_en) rd_mux = {2'b00, patch_slot_enable_ff[5:0]}; // [R04] [R07]
    if (sel_open) rd_mux = {2'b00, patch_data_read_open_ff[5:0]}; // [R16]
    for (int k = 0; k < SLOTS; k++) begin
      if (rd_sel[k]) rd_mux = rd_val[k]; // [R05] [R06]
    end
  end

  // Lowest numbered slot wins if software programs two slots alike
  rpu_byte_t sub_data;
  always_comb begin
    sub_data = rom_rdata; // [R03]
    for (int k = SLOTS - 1; k >= 0; k--) begin
      if (hit[k]) sub_data = slot_dat[k]; // [R02]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      patch_slot_enable_ff    <= `RPU_ENABLE_RST;    // [R17]
      patch_data_read_open_ff <= `RPU_READ_OPEN_RST; // [R17]
      ack_ff                  <= 1'b0;
      rdata_ff                <= 8'h00;
    end else begin
      if (bus_wr && sel_en) patch_slot_enable_ff <= {2'b00, bus.wdata[5:0]}; // [R01] [R04]
      if (bus_wr && sel_open) patch_data_read_open_ff <= {2'b00, bus.wdata[5:0]}; // [R16]
      ack_ff   <= bus.req;
      rdata_ff <= bus.req && !bus.we ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fetch_data_ff    <= 8'h00;
      fetch_valid_ff   <= 1'b0;
      fetch_patched_ff <= 1'b0;
    end else begin
      fetch_valid_ff   <= rom_rd;
      fetch_data_ff    <= rom_rd ? sub_data : 8'h00;         // [R02] [R03]
      fetch_patched_ff <= rom_rd && (hit != '0);             // [R02]
    end
  end

  assign bus.ack       = ack_ff;
  assign bus.rdata     = rdata_ff;
  assign fetch_data    = fetch_data_ff;
  assign fetch_valid   = fetch_valid_ff;
  assign fetch_patched = fetch_patched_ff;
endmodule // rpu_device

// ---- rtl/rpu_ctl.sv ----
// Controller end: APB command registers that drive internal-bus accesses
`timescale 1ns/100ps
`include "rpu_map.svh"
module rpu_ctl
  import rpu_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  rpu_if.ctl               bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready
);
  rpu_state_e  state_ff;
  rpu_state_e  nxt_state;
  rpu_addr_t   cmd_addr_ff;
  rpu_byte_t   cmd_wdata_ff;
  rpu_byte_t   last_rdata_ff;
  logic        cmd_we_ff;
  logic        req_ff;
  logic        pready_ff;
  logic [31:0] prdata_ff;

  // One wait state: pready rises one edge into the access phase
  wire apb_done  = psel && penable && pready_ff;
  wire apb_wr    = apb_done && pwrite;
  wire wr_addr   = apb_wr && paddr == `RPU_APB_CMD_ADDR;
  wire wr_wdata  = apb_wr && paddr == `RPU_APB_CMD_WDATA;
  wire wr_ctrl   = apb_wr && paddr == `RPU_APB_CMD_CTRL;
  wire go_write  = wr_ctrl && pwdata[`RPU_CTRL_WRITE_BIT];
  wire go_read   = wr_ctrl && !pwdata[`RPU_CTRL_WRITE_BIT] && pwdata[`RPU_CTRL_READ_BIT];
  wire busy      = state_ff != RPU_IDLE;
  // Ordering of slot programming is software's job; commands are issued as written
  wire start     = (go_write || go_read) && !busy; // [R09] [R10] [R11]

  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      `RPU_APB_CMD_ADDR:  rd_mux = {16'h0000, cmd_addr_ff};
      `RPU_APB_CMD_WDATA: rd_mux = {24'h00_0000, cmd_wdata_ff};
      `RPU_APB_STATUS:    rd_mux = {16'h0000, last_rdata_ff, 7'h00, busy};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    case (state_ff)
      RPU_IDLE:  nxt_state = start ? RPU_ISSUE : RPU_IDLE;
      RPU_ISSUE: nxt_state = RPU_WAIT;
      RPU_WAIT:  nxt_state = bus.ack ? RPU_IDLE : RPU_WAIT;
      default:   nxt_state = RPU_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      prdata_ff <= (psel && penable && !pready_ff && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff      <= RPU_IDLE;
      cmd_addr_ff   <= 16'h0000;
      cmd_wdata_ff  <= 8'h00;
      cmd_we_ff     <= 1'b0;
      req_ff        <= 1'b0;
      last_rdata_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (wr_addr && !busy) cmd_addr_ff <= pwdata[15:0];
      if (wr_wdata && !busy) cmd_wdata_ff <= pwdata[7:0];
      if (start) cmd_we_ff <= go_write;
      req_ff <= start;
      if (state_ff == RPU_WAIT && bus.ack && !cmd_we_ff) last_rdata_ff <= bus.rdata;
    end
  end

  assign bus.req   = req_ff;
  assign bus.we    = cmd_we_ff;
  assign bus.addr  = cmd_addr_ff;
  assign bus.wdata = cmd_wdata_ff;
  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
endmodule // rpu_ctl

// ---- sim/rpu_asserts.sv ----
// Protocol and register readback checks on the patch unit internal bus
`timescale 1ns/100ps
module rpu_asserts (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        ack,
  input wire logic [7:0]  rdata
);
  logic [7:0] en_ff;
  logic [7:0] open_ff;
  wire        rd_req = req && !we;

  // Shadows of the last written enable and read-open bytes
  always_ff @(posedge core_clk) begin
    if (srst) en_ff <= 8'h00;
    else if (req && we && addr == 16'h0077) en_ff <= wdata;
  end
  always_ff @(posedge core_clk) begin
    if (srst) open_ff <= 8'h00;
    else if (req && we && addr == 16'h0078) open_ff <= wdata;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_ack_one_cycle: assert property (req |=> ack)
    else $error("ack missing after req");
  a_ack_has_cause: assert property (ack |-> $past(req))
    else $error("ack without req");
  a_req_one_pulse: assert property (req |=> !req)
    else $error("req longer than one cycle");
  a_write_rdata_zero: assert property (req && we |=> rdata == 8'h00)
    else $error("rdata not zero on write");
  a_enable_readback: assert property (rd_req && addr == 16'h0077 |=> rdata == {2'b00, en_ff[5:0]})
    else $error("enable readback wrong");
  a_open_readback: assert property (rd_req && addr == 16'h0078 |=> rdata == {2'b00, open_ff[5:0]})
    else $error("read-open readback wrong");
  a_closed_data_zero: assert property (rd_req && addr == 16'h0C82 && !open_ff[0] |=> rdata == 8'h00)
    else $error("closed data register readable");
  a_unmapped_zero: assert property (rd_req && addr == 16'h0000 |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  c_enable_read: cover property (rd_req && addr == 16'h0077);
  c_data_write: cover property (req && we && addr == 16'h0C82);
  c_open_read: cover property (rd_req && addr == 16'h0C82 && open_ff[0]);
endmodule // rpu_asserts

// ---- sim/rom_patch_unit_tb.sv ----
// Testbench for the patch unit driven through the APB controller
`timescale 1ns/100ps
`include "rpu_map.svh"
module rom_patch_unit_tb;
  import rpu_pkg::*;
  logic        core_clk, srst, psel, penable, pwrite, pready, rom_rd;
  logic        fetch_valid, fetch_patched;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_word;
  rpu_addr_t   rom_addr;
  rpu_byte_t   rom_rdata, fetch_data, rd_byte;
  int          mismatches, total_checks, cyc;

  rpu_if bus_if ();
  rpu_ctl i_rpu_ctl (.core_clk(core_clk), .srst(srst), .bus(bus_if.ctl), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready));
  rpu_device #(.SLOTS(6)) i_rpu_device (.core_clk(core_clk), .srst(srst), .bus(bus_if.dev),
    .rom_rd(rom_rd), .rom_addr(rom_addr), .rom_rdata(rom_rdata), .fetch_data(fetch_data),
    .fetch_valid(fetch_valid), .fetch_patched(fetch_patched));
  rpu_asserts i_rpu_asserts (.core_clk(core_clk), .srst(srst), .req(bus_if.req),
    .we(bus_if.we), .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack),
    .rdata(bus_if.rdata));

  always #50 core_clk = ~core_clk;

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      $display("ERROR %0t timeout", $time);
      print_verdict;
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen at an edge; one idle edge before the next setup
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd_word = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task dev(input logic w, input rpu_addr_t a, input rpu_byte_t d);
    apb(1'b1, `RPU_APB_CMD_ADDR, {16'h0000, a});
    apb(1'b1, `RPU_APB_CMD_WDATA, {24'h00_0000, d});
    apb(1'b1, `RPU_APB_CMD_CTRL, w ? 32'h0000_0001 : 32'h0000_0002);
    do apb(1'b0, `RPU_APB_STATUS, 32'h0000_0000); while (rd_word[0] !== 1'b0);
    rd_byte = rd_word[15:8];
  endtask

  // The ROM lines are scrambled after the fetch so a late sample shows up
  task fetch(input rpu_addr_t a, input rpu_byte_t exp, input logic hit);
    rom_rd <= 1'b1;
    rom_addr <= a;
    rom_rdata <= 8'hA5;
    @(posedge core_clk);
    rom_rd <= 1'b0;
    rom_addr <= ~a;
    rom_rdata <= 8'h5A;
    @(posedge core_clk);
    check(fetch_valid, 1'b1);
    check(fetch_data, exp);
    check(fetch_patched, hit);
  endtask

  task t_reset;
    dev(1'b0, `RPU_ENABLE_ADDR, 8'h00);
    check(rd_byte, `RPU_ENABLE_RST);
    dev(1'b0, `RPU_READ_OPEN_ADDR, 8'h00);
    check(rd_byte, `RPU_READ_OPEN_RST);
    fetch(16'h0000, 8'hA5, 1'b0);
    $display("test reset done");
  endtask

  task t_regs;
    dev(1'b1, `RPU_ENABLE_ADDR, 8'hFF);
    dev(1'b0, `RPU_ENABLE_ADDR, 8'h00);
    check(rd_byte, 8'h3F);
    dev(1'b1, `RPU_READ_OPEN_ADDR, 8'hFF);
    dev(1'b0, `RPU_READ_OPEN_ADDR, 8'h00);
    check(rd_byte, 8'h3F);
    dev(1'b1, `RPU_READ_OPEN_ADDR, 8'h00);
    dev(1'b1, `RPU_ENABLE_ADDR, 8'h00);
    dev(1'b0, 16'h0000, 8'h00);
    check(rd_byte, 8'h00);
    $display("test registers done");
  endtask

  task t_patch;
    rpu_addr_t b;
    for (rpu_byte_t n = 0; n < 6; n++) begin
      b = `RPU_SLOT_BASE + {8'h00, n} * `RPU_SLOT_STRIDE;
      dev(1'b1, b, 8'h20 + n);
      dev(1'b1, b + 16'h0001, 8'h40 + n);
      dev(1'b1, b + 16'h0002, 8'hC0 + n);
      dev(1'b0, b, 8'h00);
      check(rd_byte, 8'h20 + n);
      dev(1'b0, b + 16'h0001, 8'h00);
      check(rd_byte, 8'h40 + n);
      dev(1'b0, b + 16'h0002, 8'h00);
      check(rd_byte, 8'h00);
    end
    // Slots are all programmed before the first fetch, as a loader would do
    dev(1'b1, `RPU_ENABLE_ADDR, 8'h3F);
    for (rpu_byte_t n = 0; n < 6; n++) begin
      fetch({8'h20 + n, 8'h40 + n}, 8'hC0 + n, 1'b1);
      fetch({8'h20 + n, 8'h41 ^ n}, 8'hA5, 1'b0);
      fetch({8'h21 ^ n, 8'h40 + n}, 8'hA5, 1'b0);
    end
    dev(1'b1, `RPU_ENABLE_ADDR, 8'h00);
    dev(1'b1, `RPU_READ_OPEN_ADDR, 8'h3F);
    for (rpu_byte_t n = 0; n < 6; n++) begin
      dev(1'b0, `RPU_SLOT_BASE + {8'h00, n} * `RPU_SLOT_STRIDE + 16'h0002, 8'h00);
      check(rd_byte, 8'hC0 + n);
    end
    dev(1'b1, `RPU_READ_OPEN_ADDR, 8'h00);
    dev(1'b1, `RPU_ENABLE_ADDR, 8'h3B);
    fetch(16'h2242, 8'hA5, 1'b0);
    fetch(16'h2343, 8'hC3, 1'b1);
    $display("test patch done");
  endtask

  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    {psel, penable, pwrite, rom_rd} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rom_addr = 16'h0000;
    rom_rdata = 8'h00;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_regs;
    t_patch;
    print_verdict;
  end
endmodule // rom_patch_unit_tb
